// ---- hdl/codec_host_pkg.sv ----
// Constants and carrier types for the codec host direct register port.
// Assumes one device clock shared by host bus, core and register logic.
package codec_host_pkg;

    // Direct byte offsets
    localparam logic [3:0] OFS_INDEX    = 4'h0;
    localparam logic [3:0] OFS_IND_DATA = 4'h4;
    localparam logic [3:0] OFS_STREAM   = 4'h8;
    localparam logic [3:0] OFS_IRQ      = 4'hC;

    // Stream buffer shape
    localparam int FIFO_DEPTH  = 512;
    localparam int FIFO_WIDTH  = 32;
    localparam int STEP_SHIFT  = 5;
    localparam int HALT_MARGIN = 32;

    // Indirect indices shadowed locally
    localparam logic [15:0] IDX_MODE      = 16'h0000;
    localparam logic [15:0] IDX_FIFO_CTRL = 16'h0001;
    localparam int          MODE_ENC_BIT  = 7;
    localparam int          MODE_POL_BIT  = 13;

    // Values after reset
    localparam logic [15:0] RST_INDEX  = 16'h0000;
    localparam logic [3:0]  RST_ESL    = 4'h8;
    localparam logic [3:0]  RST_DSL    = 4'h8;
    localparam logic        RST_ENCODE = 1'b1;
    localparam logic        RST_POL    = 1'b0;
    localparam logic [6:0]  RST_EN     = 7'h00;

    // Status bit positions; enable of bit k sits at k + 8
    localparam int NUM_STATUS  = 7;
    localparam int ST_SYNC     = 0;
    localparam int ST_STATS    = 1;
    localparam int ST_LAST     = 2;
    localparam int ST_SERVICE  = 3;
    localparam int ST_FAULT    = 4;
    localparam int ST_HALT     = 5;
    localparam int ST_DRAM     = 6;
    localparam int EN_BASE     = 8;
    localparam logic [6:0] STICKY_MASK = 7'h77;

    typedef struct packed {
        logic        sel;
        logic        wr;
        logic [3:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } host_req_t;

endpackage

// ---- hdl/codec_stream_fifo.sv ----
// Flip-flop FIFO behind the compressed stream register.
// Assumes DEPTH is a power of two; push when full and pop when empty drop.
`timescale 1ns/1ns
`default_nettype none
module codec_stream_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 512,
    parameter int CW    = $clog2(DEPTH) + 1
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_b_i,
    input  wire logic             push_i,
    input  wire logic [WIDTH-1:0] push_data_i,
    input  wire logic             pop_i,
    output logic      [WIDTH-1:0] head_o,
    output logic      [CW-1:0]    count_o,
    output logic                  full_o,
    output logic                  avail_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [CW-1:0]    count_d;
    logic             do_push;
    logic             do_pop;

    assign do_push = push_i && !full_o;
    assign do_pop  = pop_i && avail_o;
    assign head_o  = mem_q[rd_ptr_q];

    always_comb begin
        count_d = count_o;
        if (do_push && !do_pop) begin
            count_d = count_o + CW'(1);
        end else if (do_pop && !do_push) begin
            count_d = count_o - CW'(1);
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= push_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_o  <= '0;
            full_o   <= 1'b0;
            avail_o  <= 1'b0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= wr_ptr_q + AW'(1);
            end
            if (do_pop) begin
                rd_ptr_q <= rd_ptr_q + AW'(1);
            end
            count_o <= count_d;
            full_o  <= (count_d == CW'(DEPTH));
            avail_o <= (count_d != '0);
        end
    end
endmodule
`default_nettype wire

// ---- hdl/codec_host_direct_registers.sv ----
// Host direct registers: indirect index/data window, stream word with
// FIFO, interrupt mask/status and host interrupt pin.
// Assumes host bus, core and indirect bank all run on clk_sys_i.
`timescale 1ns/1ns
`default_nettype none

module codec_host_direct_registers
    import codec_host_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int WIDTH = FIFO_WIDTH
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_b_i,
    input  wire host_req_t        host_req_i,
    output logic      [31:0]      host_rdata_o,
    output logic                  host_rvalid_o,
    output logic                  host_irq_pin_o,
    output logic      [15:0]      ind_index_o,
    output logic      [15:0]      ind_waddr_o,
    output logic      [15:0]      ind_wdata_o,
    output logic                  ind_wr_o,
    output logic                  ind_rd_o,
    input  wire logic [15:0]      ind_rdata_i,
    input  wire logic             enc_push_i,
    input  wire logic [WIDTH-1:0] enc_data_i,
    output logic                  enc_full_o,
    input  wire logic             dec_pop_i,
    output logic      [WIDTH-1:0] dec_data_o,
    output logic                  dec_valid_o,
    input  wire logic             sync_code_error_i,
    input  wire logic             stats_ready_i,
    input  wire logic             last_word_i,
    input  wire logic             dram_fault_i,
    output logic                  stats_ready_pin_o,
    output logic                  last_word_pin_o,
    output logic                  fifo_service_pin_o,
    output logic                  fifo_fault_pin_o,
    output logic                  fifo_halt_pin_o
);
    localparam int CW = $clog2(DEPTH) + 1;

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_b_i);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                                input logic [31:0] neu,
                                                input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = neu[i*8 +: 8];
            end
        end
        return res;
    endfunction

    logic [15:0]            index_q;
    logic [7:0]             lo_hold_q;
    logic [31:0]            stream_hold_q;
    logic                   enc_q;
    logic                   pol_q;
    logic [3:0]             esl_q;
    logic [3:0]             dsl_q;
    logic [NUM_STATUS-1:0]  en_q;
    logic [NUM_STATUS-1:0]  cond_d;
    logic [NUM_STATUS-1:0]  cond_q;
    logic [NUM_STATUS-1:0]  status_q;
    logic [NUM_STATUS-1:0]  rise;
    logic [NUM_STATUS-1:0]  view;
    logic                   irq_any;
    logic                   sel_idx;
    logic                   sel_ind;
    logic                   sel_strm;
    logic                   sel_irq;
    logic                   ind_step;
    logic                   ind_wr_go;
    logic [15:0]            ind_word;
    logic                   rd_irq;
    logic                   host_push;
    logic                   host_pop;
    logic [31:0]            stream_word;
    logic                   fifo_push;
    logic                   fifo_pop;
    logic [WIDTH-1:0]       fifo_in;
    logic [WIDTH-1:0]       fifo_head;
    logic [CW-1:0]          fifo_count;
    logic                   fifo_full;
    logic                   fifo_avail;
    logic                   fault_evt;
    logic                   service;
    logic                   halt;

    // Direct decode on word address
    // four direct offsets
    assign sel_idx  = host_req_i.sel && host_req_i.addr[3:2] == OFS_INDEX[3:2];
    assign sel_ind  = host_req_i.sel
                      && host_req_i.addr[3:2] == OFS_IND_DATA[3:2];
    assign sel_strm = host_req_i.sel && host_req_i.addr[3:2] == OFS_STREAM[3:2];
    assign sel_irq  = host_req_i.sel && host_req_i.addr[3:2] == OFS_IRQ[3:2];
    assign rd_irq   = sel_irq && !host_req_i.wr;

    assign ind_step  = sel_ind && host_req_i.be[1];
    assign ind_wr_go = ind_step && host_req_i.wr;
    assign ind_word  = {host_req_i.wdata[15:8],
                        host_req_i.be[0] ? host_req_i.wdata[7:0] : lo_hold_q};

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            index_q <= RST_INDEX;
        end else if (ind_step) begin
            index_q <= index_q + 16'h0001;
        end else if (sel_idx && host_req_i.wr) begin
            index_q <= merge_bytes({16'h0000, index_q}, host_req_i.wdata,
                                   host_req_i.be & 4'b0011)
                       [15:0];
        end
    end
    assign ind_index_o = index_q;

    idx_step_a: assert property (ind_step |=> index_q == $past(index_q) + 16'h0001)
        else $error("index did not advance after high byte access");
    lo_no_step_a: assert property (sel_ind && host_req_i.be == 4'b0001
                                   && !sel_idx |=> index_q == $past(index_q))
        else $error("index moved on low byte access");

    // Indirect write path
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lo_hold_q   <= 8'h00;
            ind_wr_o    <= 1'b0;
            ind_rd_o    <= 1'b0;
            ind_wdata_o <= 16'h0000;
            ind_waddr_o <= RST_INDEX;
        end else begin
            if (sel_ind && host_req_i.wr && host_req_i.be[0]) begin
                lo_hold_q <= host_req_i.wdata[7:0];
            end
            ind_wr_o <= ind_wr_go;
            ind_rd_o <= ind_step && !host_req_i.wr;
            if (ind_wr_go) begin
                ind_wdata_o <= ind_word;
                ind_waddr_o <= index_q;
            end
        end
    end

    ind_wr_a: assert property (ind_wr_go |=> ind_wr_o
                               && ind_wdata_o == $past(ind_word)
                               && ind_waddr_o == $past(index_q))
        else $error("indirect write word or address wrong");

    // Shadow of mode and FIFO control fields
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enc_q <= RST_ENCODE;
            pol_q <= RST_POL;
            esl_q <= RST_ESL;
            dsl_q <= RST_DSL;
        end else if (ind_wr_go) begin
            if (index_q == IDX_MODE) begin
                enc_q <= ind_word[MODE_ENC_BIT];
                pol_q <= ind_word[MODE_POL_BIT];
            end else if (index_q == IDX_FIFO_CTRL) begin
                esl_q <= ind_word[3:0];
                dsl_q <= ind_word[7:4];
            end
        end
    end

    // Stream word assembly, completes on byte 3
    // ascending lanes
    assign stream_word = merge_bytes(stream_hold_q, host_req_i.wdata,
                                     host_req_i.be);
    assign host_push   = sel_strm && host_req_i.wr && host_req_i.be[3] && !enc_q;
    assign host_pop    = sel_strm && !host_req_i.wr && host_req_i.be[3] && enc_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stream_hold_q <= 32'h0000_0000;
        end else if (sel_strm && host_req_i.wr && !enc_q) begin
            stream_hold_q <= stream_word;
        end
    end

    assign fifo_push = enc_q ? enc_push_i : host_push;
    assign fifo_pop  = enc_q ? host_pop : dec_pop_i;
    assign fifo_in   = enc_q ? enc_data_i : WIDTH'(stream_word);

    codec_stream_fifo #(
        .WIDTH (WIDTH),
        .DEPTH (DEPTH),
        .CW    (CW)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_b_i     (rst_b_i),
        .push_i      (fifo_push),
        .push_data_i (fifo_in),
        .pop_i       (fifo_pop),
        .head_o      (fifo_head),
        .count_o     (fifo_count),
        .full_o      (fifo_full),
        .avail_o     (fifo_avail)
    );

    assign enc_full_o  = fifo_full;
    assign dec_valid_o = fifo_avail;
    assign dec_data_o  = fifo_head;

    // Live conditions
    // overflow, underflow, overfill
    assign fault_evt = enc_q ? (enc_push_i && fifo_full)
                             : ((dec_pop_i && !fifo_avail)
                                || (host_push && fifo_full));
    assign service = enc_q
        ? (esl_q != 4'h0 && fifo_count >= (CW'(esl_q) << STEP_SHIFT))
        : (dsl_q != 4'h0 && fifo_count <= (CW'(dsl_q) << STEP_SHIFT));
    assign halt = enc_q ? !fifo_avail
                        : (fifo_count >= CW'(DEPTH - HALT_MARGIN));

    always_comb begin
        cond_d             = '0;
        cond_d[ST_SYNC]    = sync_code_error_i;
        cond_d[ST_STATS]   = stats_ready_i;
        cond_d[ST_LAST]    = last_word_i;
        cond_d[ST_SERVICE] = service;
        cond_d[ST_FAULT]   = fault_evt;
        cond_d[ST_HALT]    = halt;
        cond_d[ST_DRAM]    = dram_fault_i;
    end
    assign rise = cond_d & ~cond_q;

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cond_q <= '0;
        end else begin
            cond_q <= cond_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~(rd_irq ? STICKY_MASK : 7'h00))
                        | (rise & STICKY_MASK);
        end
    end

    sticky_hold_a: assert property (status_q[ST_SYNC] && !rd_irq
                                    |=> status_q[ST_SYNC])
        else $error("sticky flag dropped without a read");
    set_wins_a: assert property (rd_irq && rise[ST_DRAM]
                                 |=> status_q[ST_DRAM])
        else $error("flag rising during read was lost");
    halt_dec_a: assert property (!enc_q
                                 && fifo_count >= CW'(DEPTH - HALT_MARGIN)
                                 |=> cond_q[ST_HALT])
        else $error("halt missing with 32 slots left");
    fault_pin_a: assert property (host_push && fifo_full
                                  && !cond_q[ST_FAULT]
                                  |=> ##1 fifo_fault_pin_o)
        else $error("overfill did not raise fault");

    always_comb begin
        view             = status_q;
        view[ST_SERVICE] = cond_q[ST_SERVICE];
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            en_q <= RST_EN;
        end else if (sel_irq && host_req_i.wr && host_req_i.be[1]) begin
            en_q <= host_req_i.wdata[EN_BASE +: NUM_STATUS];
        end
    end

    assign irq_any = |(view & en_q);

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            host_irq_pin_o <= !RST_POL;
        end else begin
            host_irq_pin_o <= pol_q ? irq_any : !irq_any;
        end
    end

    irq_combine_a: assert property (1'b1 |=> host_irq_pin_o
                                    == ($past(pol_q) ? $past(irq_any)
                                                     : !$past(irq_any)))
        else $error("interrupt pin does not follow masked status");

    // Status mirror pins
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stats_ready_pin_o  <= 1'b0;
            last_word_pin_o    <= 1'b0;
            fifo_service_pin_o <= 1'b0;
            fifo_fault_pin_o   <= 1'b0;
            fifo_halt_pin_o    <= 1'b0;
        end else begin
            stats_ready_pin_o  <= cond_d[ST_STATS];
            last_word_pin_o    <= cond_d[ST_LAST];
            fifo_service_pin_o <= cond_d[ST_SERVICE];
            fifo_fault_pin_o   <= status_q[ST_FAULT];
            fifo_halt_pin_o    <= cond_d[ST_HALT];
        end
    end

    // Read data, one cycle after the request
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            host_rdata_o  <= 32'h0000_0000;
            host_rvalid_o <= 1'b0;
        end else begin
            host_rvalid_o <= host_req_i.sel && !host_req_i.wr;
            host_rdata_o  <= 32'h0000_0000;
            if (sel_ind) begin
                host_rdata_o <= {16'h0000, ind_rdata_i};
            end else if (sel_strm && enc_q) begin
                host_rdata_o <= 32'(fifo_head);
            end else if (sel_irq) begin
                host_rdata_o <= {16'h0000, 1'b0, en_q, 1'b0, view};
            end
        end
    end

    live_bit_a: assert property (rd_irq |=> host_rdata_o[ST_SERVICE]
                                 == $past(cond_q[ST_SERVICE]))
        else $error("service bit not live on read");
    rsv_zero_a: assert property (rd_irq |=> host_rdata_o[7] == 1'b0
                                 && host_rdata_o[15] == 1'b0)
        else $error("reserved status bits not zero");

    cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) ind_wr_go);
    cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
                    fifo_full && host_push);
    cover property (@(posedge clk_sys_i) disable iff (!rst_b_i)
                    rd_irq && |status_q);
endmodule
`default_nettype wire

// ---- verif/host_model.sv ----
// Host processor model driving the direct register port.
// Assumes one request per access and a read answer within two cycles.
`timescale 1ns/1ns
`default_nettype none
module host_model
    import codec_host_pkg::*;
(
    input  wire logic        clk_sys_i,
    input  wire logic [31:0] rdata_i,
    input  wire logic        rvalid_i,
    output var  host_req_t   req_o
);
    initial req_o = '0;

    // One-cycle request, launched off the falling edge
    task automatic access(input logic wr, input logic [3:0] addr,
                          input logic [3:0] be, input logic [31:0] wd,
                          output logic [31:0] rd);
        rd = '0;
        @(negedge clk_sys_i);
        req_o = '{sel: 1'b1, wr: wr, addr: addr, be: be, wdata: wd};
        @(negedge clk_sys_i);
        req_o = '0;
        if (!wr) begin
            if (rvalid_i !== 1'b1) begin
                @(negedge clk_sys_i);
            end
            rd = rdata_i;
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Self-checking bench for the host direct register port.
// Assumes the host model drives the bus; the bench drives core inputs.
`timescale 1ns/1ns
`default_nettype none
module testbench
    import codec_host_pkg::*;
;
    logic        clk_sys, rst_b, irq, iwr, push, sync_e, stats, last;
    logic        dram, stats_pin, rvalid, svc;
    logic [15:0] idx, waddr, wd16, base;
    logic [31:0] rdata, rd, pdata, lf, v;
    host_req_t   req;
    logic [31:0] q[$];
    int          err_total, n_checks, i;

    codec_host_direct_registers codec_host_direct_registers_i (
        .clk_sys_i(clk_sys), .rst_b_i(rst_b), .host_req_i(req),
        .host_rdata_o(rdata), .host_rvalid_o(rvalid),
        .host_irq_pin_o(irq), .ind_index_o(idx), .ind_waddr_o(waddr),
        .ind_wdata_o(wd16), .ind_wr_o(iwr), .ind_rd_o(),
        .ind_rdata_i(~idx), .enc_push_i(push), .enc_data_i(pdata),
        .enc_full_o(), .dec_pop_i(1'b0), .dec_data_o(), .dec_valid_o(),
        .sync_code_error_i(sync_e), .stats_ready_i(stats),
        .last_word_i(last), .dram_fault_i(dram),
        .stats_ready_pin_o(stats_pin), .last_word_pin_o(),
        .fifo_service_pin_o(svc), .fifo_fault_pin_o(), .fifo_halt_pin_o()
    );
    host_model host_model_i (
        .clk_sys_i(clk_sys), .rdata_i(rdata), .rvalid_i(rvalid),
        .req_o(req)
    );

    always #2 clk_sys = ~clk_sys;

    function logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #40000;
        err_total++;
        results();
    end

    initial begin
        clk_sys = 1'b0; rst_b = 1'b0; push = 1'b0; pdata = '0;
        sync_e = 1'b0; stats = 1'b0; last = 1'b0; dram = 1'b0;
        err_total = 0; n_checks = 0; lf = 32'hfa1c_de6c;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys) rst_b = 1'b1;
        chk(32'(irq), 32'h0000_0001);
        host_model_i.access(1'b0, 4'hC, 4'hF, '0, rd);
        chk(32'({rd[15:7], rd[0]}), '0);
        for (i = 0; i < 4; i++) begin
            v = rnd();
            base = v[15:0];
            host_model_i.access(1'b1, 4'h0, 4'hF, {16'h0, base}, rd);
            host_model_i.access(1'b1, 4'h4, 4'hF, {16'h0, v[31:16]}, rd);
            chk(32'(iwr), 32'h0000_0001);
            chk(32'(waddr), 32'(base));
            chk(32'(wd16), 32'(v[31:16]));
            chk(32'(idx), 32'(16'(base + 16'h1)));
            host_model_i.access(1'b0, 4'h4, 4'hF, '0, rd);
            chk(rd, {16'h0, ~16'(base + 16'h1)});
            // low byte first, then high byte
            host_model_i.access(1'b1, 4'h4, 4'h1, {24'h0, v[7:0]}, rd);
            chk(32'(idx), 32'(16'(base + 16'h2)));
            host_model_i.access(1'b1, 4'h4, 4'h2, {16'h0, v[15:8], 8'h0}, rd);
            chk(32'(wd16), 32'(v[15:0]));
            chk(32'(idx), 32'(16'(base + 16'h3)));
        end
        host_model_i.access(1'b1, 4'hC, 4'h2, 32'h0000_4000, rd);
        @(negedge clk_sys);
        dram = 1'b1;
        stats = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk(32'(irq), '0);
        chk(32'(stats_pin), 32'h0000_0001);
        host_model_i.access(1'b0, 4'hC, 4'hF, '0, rd);
        chk(rd, 32'h0000_4042);
        host_model_i.access(1'b0, 4'hC, 4'hF, '0, rd);
        chk(rd, 32'h0000_4000);
        chk(32'(irq), 32'h0000_0001);
        dram = 1'b0;
        stats = 1'b0;
        // Encode service level of one step, decode level off
        host_model_i.access(1'b1, 4'h0, 4'hF, 32'h0000_0001, rd);
        host_model_i.access(1'b1, 4'h4, 4'hF, 32'h0000_0001, rd);
        for (i = 0; i < 32; i++) begin
            @(negedge clk_sys);
            push = 1'b1;
            pdata = rnd();
            q.push_back(pdata);
        end
        @(negedge clk_sys) push = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk(32'(svc), 32'h0000_0001);
        host_model_i.access(1'b0, 4'hC, 4'hF, '0, rd);
        chk(rd, 32'h0000_4008);
        while (q.size() > 0) begin
            // whole word read with byte 3
            host_model_i.access(1'b0, 4'h8, 4'hF, '0, rd);
            chk(rd, q.pop_front());
        end
        host_model_i.access(1'b1, 4'h0, 4'hF, '0, rd);
        host_model_i.access(1'b1, 4'h4, 4'hF, 32'h0000_2080, rd);
        repeat (2) @(negedge clk_sys);
        chk(32'(irq), '0);
        results();
    end
endmodule
`default_nettype wire
